/* File: rtl/drc_consts.svh */
// Purpose: Timing and width constants for the DRAM host controller.
// Assumes: 250 MHz system clock, 4 ns period.
// Notes:   Long counts are derived from times in their printed units.
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH
`define DRC_CLK_MHZ        250
`define DRC_ROWS           256
`define DRC_INIT_CYCLES    4'h8
`define DRC_PWRUP_US       1000
`define DRC_REFRESH_US     4400
`define DRC_PHASE_NS       20
`define DRC_PHASE_CYC      ((`DRC_PHASE_NS * `DRC_CLK_MHZ + 999) / 1000)
`define DRC_PWRUP_CYC      (`DRC_PWRUP_US * `DRC_CLK_MHZ)
`define DRC_REF_INT_CYC    ((`DRC_REFRESH_US * `DRC_CLK_MHZ) / `DRC_ROWS)
`endif

/* File: rtl/drc_pkg.sv */
// Purpose: Types for the DRAM host controller.
// Assumes: Nothing beyond the constants header.
// Notes:   States are an enum with default sequential codes from 0.
`default_nettype none
package drc_pkg;
   typedef enum logic [3:0] {
      ST_PWRUP, ST_INIT, ST_IDLE, ST_ROW, ST_COL, ST_WRITE,
      ST_CBR_CAS, ST_CBR_RAS, ST_PRE
   } drc_state_type;
endpackage : drc_pkg
`default_nettype wire

/* File: rtl/drc_host.sv */
// Purpose: Host controller driving a 256K x 1 asynchronous DRAM.
// Assumes: Pins sampled synchronously; one request at a time.
// Notes:   The rules that this controller keeps are listed below.
`timescale 1ns/1ps
`default_nettype none
`include "drc_consts.svh"
module drc_host #(
   parameter int unsigned PWRUP_CYC   = `DRC_PWRUP_CYC,
   parameter int unsigned REF_INT_CYC = `DRC_REF_INT_CYC
) (
   // Clock and reset.
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   // User request port.
   input  wire logic        req_valid_i,
   input  wire logic        req_write_i,
   input  wire logic        req_rmw_i,
   input  wire logic [17:0] req_addr_i,
   input  wire logic        req_wdata_i,
   output logic             req_ready_o,
   output logic             rsp_valid_o,
   output logic             rsp_rdata_o,
   output logic             init_done_o,
   // DRAM pins.
   output logic             ras_n_o,
   output logic             cas_n_o,
   output logic             we_n_o,
   output logic [8:0]       addr_o,
   output logic             din_o,
   input  wire logic        dout_i
);
   typedef struct packed {
      drc_pkg::drc_state_type st;
      logic [31:0] tmr;
      logic [31:0] ref_tmr;
      logic [3:0]  init_cnt;
      logic        ref_pend;
      logic        write;
      logic        rmw;
      logic [17:0] addr;
      logic        wdata;
      logic        ready;
      logic        rvalid;
      logic        rdata;
      logic        done;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [8:0]  a;
      logic        din;
   } drc_regs_type;

   localparam logic [31:0] PHASE = 32'(`DRC_PHASE_CYC);

   drc_regs_type st_reg;
   drc_regs_type st_next;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole controller.
   always_comb begin
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      st_next.ready = 1'b0;
      // Refresh interval timer spreads 256 refreshes over the period.
      if (st_reg.ref_tmr >= REF_INT_CYC - 1) begin
         st_next.ref_tmr = 32'h0000_0000;
         st_next.ref_pend = 1'b1;
      end else begin
         st_next.ref_tmr = st_reg.ref_tmr + 32'h0000_0001;
      end
      if (st_reg.tmr != 32'h0000_0000) begin
         st_next.tmr = st_reg.tmr - 32'h0000_0001;
      end
      case (st_reg.st)
         drc_pkg::ST_PWRUP: begin
            // Hold all strobes high for the power-up pause.
            if (st_reg.tmr == 32'h0000_0000) begin
               st_next.st = drc_pkg::ST_INIT;
               st_next.init_cnt = 4'h0;
            end
         end
         drc_pkg::ST_INIT: begin
            // Eight initialization cycles as refresh cycles.
            if (st_reg.init_cnt == `DRC_INIT_CYCLES) begin
               st_next.done = 1'b1;
               st_next.st = drc_pkg::ST_IDLE;
            end else begin
               st_next.init_cnt = st_reg.init_cnt + 4'h1;
               st_next.cas_n = 1'b0;
               st_next.tmr = PHASE;
               st_next.st = drc_pkg::ST_CBR_CAS;
            end
         end
         drc_pkg::ST_IDLE: begin
            // Refresh wins over user requests; it also keeps ready low.
            if (st_reg.ref_pend) begin
               // A timer tick in this same cycle keeps the flag set.
               if (st_reg.ref_tmr < REF_INT_CYC - 1) begin
                  st_next.ref_pend = 1'b0;
               end
               st_next.cas_n = 1'b0;
               st_next.tmr = PHASE;
               st_next.st = drc_pkg::ST_CBR_CAS;
            end else if (req_valid_i) begin
               st_next.write = req_write_i | req_rmw_i;
               st_next.rmw = req_rmw_i;
               st_next.addr = req_addr_i;
               st_next.wdata = req_wdata_i;
               st_next.a = req_addr_i[17:9];
               st_next.tmr = PHASE;
               st_next.st = drc_pkg::ST_ROW;
            end
         end
         drc_pkg::ST_ROW: begin
            // Row address set up, CAS high: RAS falls and latches the row.
            if (st_reg.tmr == 32'h0000_0000) begin
               st_next.ras_n = 1'b0;
               st_next.we_n = !(st_reg.write && !st_reg.rmw);
               st_next.din = st_reg.wdata;
               st_next.tmr = PHASE;
               st_next.st = drc_pkg::ST_COL;
            end
         end
         drc_pkg::ST_COL: begin
            // Column address then CAS; read data valid after one phase.
            if (st_reg.tmr == PHASE - 32'h0000_0001) begin
               st_next.a = st_reg.addr[8:0];
            end
            if (st_reg.tmr == 32'h0000_0000) begin
               if (st_reg.cas_n) begin
                  st_next.cas_n = 1'b0;
                  st_next.tmr = PHASE;
               end else begin
                  st_next.rdata = dout_i;
                  st_next.tmr = PHASE;
                  if (st_reg.rmw) begin
                     st_next.we_n = 1'b0;
                  end
                  st_next.st = drc_pkg::ST_WRITE;
               end
            end
         end
         drc_pkg::ST_WRITE: begin
            // Write pulse time, then release all strobes together.
            if (st_reg.tmr == 32'h0000_0000) begin
               st_next.ras_n = 1'b1;
               st_next.cas_n = 1'b1;
               st_next.we_n = 1'b1;
               st_next.rvalid = !st_reg.write || st_reg.rmw;
               st_next.tmr = PHASE;
               st_next.st = drc_pkg::ST_PRE;
            end
         end
         drc_pkg::ST_CBR_CAS: begin
            // CAS already low when RAS falls; address and WE ignored.
            if (st_reg.tmr == 32'h0000_0000) begin
               st_next.ras_n = 1'b0;
               st_next.tmr = PHASE;
               st_next.st = drc_pkg::ST_CBR_RAS;
            end
         end
         drc_pkg::ST_CBR_RAS: begin
            // Refresh only; no data is taken from the output.
            if (st_reg.tmr == 32'h0000_0000) begin
               st_next.ras_n = 1'b1;
               st_next.cas_n = 1'b1;
               st_next.tmr = PHASE;
               st_next.st = drc_pkg::ST_PRE;
            end
         end
         drc_pkg::ST_PRE: begin
            // Precharge before the next cycle.
            if (st_reg.tmr == 32'h0000_0000) begin
               if (st_reg.done) begin
                  st_next.st = drc_pkg::ST_IDLE;
                  // Ready stays low while a refresh waits to go first.
                  st_next.ready = !st_next.ref_pend;
               end else begin
                  st_next.st = drc_pkg::ST_INIT;
               end
            end
         end
         default: begin
            st_next.st = drc_pkg::ST_IDLE;
         end
      endcase
      if (st_next.st != drc_pkg::ST_IDLE) begin
         st_next.ready = 1'b0;
      end else if (st_reg.st == drc_pkg::ST_IDLE) begin
         st_next.ready = !st_next.ref_pend && !req_valid_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register with synchronous reset.
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         st_reg <= '0;
         st_reg.st <= drc_pkg::ST_PWRUP;
         st_reg.tmr <= PWRUP_CYC;
         st_reg.ras_n <= 1'b1;
         st_reg.cas_n <= 1'b1;
         st_reg.we_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register.
   assign req_ready_o = st_reg.ready;
   assign rsp_valid_o = st_reg.rvalid;
   assign rsp_rdata_o = st_reg.rdata;
   assign init_done_o = st_reg.done;
   assign ras_n_o     = st_reg.ras_n;
   assign cas_n_o     = st_reg.cas_n;
   assign we_n_o      = st_reg.we_n;
   assign addr_o      = st_reg.a;
   assign din_o       = st_reg.din;
endmodule : drc_host
`default_nettype wire

/* File: sim/drc_host_props.sv */
// Purpose: Pin assertions for the DRAM host controller.
// Assumes: Sim-sized counts handed on by the bind.
// Notes:   Helper counters time power-up, refresh and idle gaps.
`timescale 1ns/1ps
`default_nettype none
module drc_host_props #(
   parameter int unsigned PWRUP_CYC   = 20,
   parameter int unsigned REF_INT_CYC = 50
) (
   // Clock, reset and status.
   input wire logic       clk_sys_i,
   input wire logic       resetn_i,
   input wire logic       init_done_o,
   // DRAM pins.
   input wire logic       ras_n_o,
   input wire logic       cas_n_o,
   input wire logic       we_n_o,
   input wire logic [8:0] addr_o,
   input wire logic       din_o
);
   int unsigned up_reg, cbr_reg, ref_reg, gap_reg;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   // Counts cycles since reset up to PWRUP_CYC, refresh cycles and row strobe gaps.
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         up_reg  <= 32'h0;
         cbr_reg <= 32'h0;
         ref_reg <= 32'h0;
         gap_reg <= 32'h0;
      end else begin
         up_reg  <= (up_reg < PWRUP_CYC) ? up_reg + 32'h1 : up_reg;
         gap_reg <= ras_n_o ? gap_reg + 32'h1 : 32'h0;
         if ($fell(ras_n_o) && !cas_n_o) begin
            cbr_reg <= cbr_reg + 32'h1;
            ref_reg <= 32'h0;
         end else ref_reg <= ref_reg + 32'h1;
      end
   end
   property p_row; $fell(ras_n_o) && cas_n_o |=> $stable(addr_o); endproperty
   a_row: assert property (p_row) else $error("row addr moved");
   property p_early; $fell(cas_n_o) && !ras_n_o && !we_n_o
      |=> $stable(addr_o) && $stable(din_o); endproperty
   a_early: assert property (p_early) else $error("early hold");
   property p_late; $fell(we_n_o) && !cas_n_o
      |-> !ras_n_o ##1 $stable(addr_o) && $stable(din_o); endproperty
   a_late: assert property (p_late) else $error("late hold");
   property p_cbr; $fell(ras_n_o) && !cas_n_o |-> !$past(cas_n_o); endproperty
   a_cbr: assert property (p_cbr) else $error("cbr setup");
   property p_pwr; $fell(ras_n_o) |-> up_reg >= PWRUP_CYC; endproperty
   a_pwr: assert property (p_pwr) else $error("early cycle");
   property p_init; $rose(init_done_o) |-> cbr_reg == 32'h8; endproperty
   a_init: assert property (p_init) else $error("init count");
   property p_ref; init_done_o |-> ref_reg <= REF_INT_CYC + 120; endproperty
   a_ref: assert property (p_ref) else $error("refresh late");
   property p_gap; init_done_o |-> gap_reg <= REF_INT_CYC + 120; endproperty
   a_gap: assert property (p_gap) else $error("row idle long");
endmodule : drc_host_props
bind drc_host drc_host_props #(.PWRUP_CYC(PWRUP_CYC),
   .REF_INT_CYC(REF_INT_CYC)) drc_host_props_i (.clk_sys_i(clk_sys_i),
   .resetn_i(resetn_i), .init_done_o(init_done_o), .ras_n_o(ras_n_o),
   .cas_n_o(cas_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .din_o(din_o));
`default_nettype wire

/* File: sim/drc_dram_model.sv */
// Purpose: Behavioural 256K x 1 DRAM facing the host controller.
// Assumes: Pins settle within 1 ns of a strobe edge.
// Notes:   A released output shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module drc_dram_model (
   // Controller pins.
   input  wire logic       ras_n_i,
   input  wire logic       cas_n_i,
   input  wire logic       we_n_i,
   input  wire logic [8:0] addr_i,
   input  wire logic       din_i,
   output logic            dout_o
);
   bit         mem [0:262143];
   logic [8:0] row_reg = 9'h000;
   logic [7:0] cnt_reg = 8'h00;
   logic       cbr_reg = 1'b0;
   initial dout_o = 1'b0;
   // Row strobe fall: latch the row, or refresh from the counter.
   always @(negedge ras_n_i) #1 begin
      cbr_reg = !cas_n_i;
      if (cbr_reg) cnt_reg = cnt_reg + 8'h01;
      else row_reg = addr_i;
   end
   // Column strobe fall: read, or early write with output left off.
   always @(negedge cas_n_i) #1 begin
      if (!ras_n_i && we_n_i) dout_o = mem[{row_reg, addr_i}];
      else if (!ras_n_i) mem[{row_reg, addr_i}] = din_i;
   end
   // Late write: the cell is written, the output holds what it showed.
   always @(negedge we_n_i) #1 begin
      if (!ras_n_i && !cas_n_i && !cbr_reg) mem[{row_reg, addr_i}] = din_i;
   end
   // Released output keeps no stale value.
   always @(posedge cas_n_i) dout_o = ~dout_o;
endmodule : drc_dram_model
`default_nettype wire

/* File: sim/drc_host_bench.sv */
// Purpose: Self-checking bench for the DRAM host controller.
// Assumes: Sim-sized power-up and refresh counts.
// Notes:   A bit array mirrors what memory must hold.
`timescale 1ns/1ps
`default_nettype none
module drc_host_bench;
   logic        clk_sys_i, resetn_i, req_valid_i, req_write_i, req_rmw_i;
   logic        req_wdata_i, req_ready_o, rsp_valid_o, rsp_rdata_o;
   logic        init_done_o, ras_n_o, cas_n_o, we_n_o, din_o, dout_i;
   logic [17:0] req_addr_i;
   logic [8:0]  addr_o;
   bit          exp_mem [0:262143];
   int          err_total, checked, seed;
   drc_host #(.PWRUP_CYC(20), .REF_INT_CYC(50)) drc_host_i (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
      .req_write_i(req_write_i), .req_rmw_i(req_rmw_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rsp_rdata_o), .init_done_o(init_done_o),
      .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
      .addr_o(addr_o), .din_o(din_o), .dout_i(dout_i));
   drc_dram_model drc_dram_model_i (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
      .we_n_i(we_n_o), .addr_i(addr_o), .din_i(din_o), .dout_o(dout_i));
   initial clk_sys_i = 1'b0;
   always #2 clk_sys_i = ~clk_sys_i;
   // Compares one bit and counts it.
   task automatic chk(input logic seen, input logic want);
      checked++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, want);
      end
   endtask : chk
   task automatic wrap_up();
      $display("%0d compared, %0d wrong", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic tick();
      @(posedge clk_sys_i) #1;
   endtask : tick
   // Waits, bounded, for ready (0), response (1) or init done (2).
   task automatic wait_for(input int k);
      for (int n = 0; (k == 0 ? req_ready_o : k == 1 ? rsp_valid_o
           : init_done_o) !== 1'b1; n++) begin
         if (n > 500) begin
            err_total++;
            wrap_up();
         end
         tick();
      end
   endtask : wait_for
   // Read (0), early write (1) or read-modify-write (2).
   task automatic op(input int kind, input logic [17:0] a, input logic wd);
      wait_for(0);
      {req_valid_i, req_write_i, req_rmw_i} = {1'b1, kind == 1, kind == 2};
      req_addr_i = a;
      req_wdata_i = wd;
      tick();
      req_valid_i = 1'b0;
      if (kind != 1) begin
         wait_for(1);
         chk(rsp_rdata_o, exp_mem[a]);
      end
      if (kind != 0) exp_mem[a] = wd;
   endtask : op
   function automatic logic [17:0] pick();
      logic [17:0] c [4] = '{18'h00000, 18'h3FFFF, 18'h001FF, 18'h3FE00};
      return c[$urandom % 4] ^ 18'($urandom % 4);
   endfunction : pick
   initial begin
      {req_valid_i, req_write_i, req_rmw_i, req_wdata_i} = 4'h0;
      req_addr_i = 18'h00000;
      resetn_i = 1'b0;
      seed = $urandom(8);
      repeat (5) tick();
      resetn_i = 1'b1;
      wait_for(2);
      for (int k = 0; k < 3; k++) op(k, 18'h3FFFF, 1'b1);
      for (int i = 0; i < 300; i++) op($urandom % 3, pick(), 1'($urandom));
      $display("random access test done");
      repeat (400) tick();
      op(0, 18'h3FFFF, 1'b0);
      $display("long idle test done");
      resetn_i = 1'b0;
      repeat (5) tick();
      resetn_i = 1'b1;
      chk(init_done_o, 1'b0);
      wait_for(2);
      op(2, 18'h00000, 1'b1);
      op(0, 18'h00000, 1'b0);
      $display("second reset test done");
      wrap_up();
   end
endmodule : drc_host_bench
`default_nettype wire
